// ===== inc/sct_consts.svh
// register indices, field positions and reset values of the smartcard timing block
// assumes byte address = 4 * index on a 32-bit bus, data in the low byte
`ifndef SCT_CONSTS_SVH
`define SCT_CONSTS_SVH
`define SCT_IDX_CTRL        4'h0
`define SCT_IDX_STATUS      4'h1
`define SCT_IDX_CONTACT     4'h2
`define SCT_IDX_BITPER_HI   4'h3
`define SCT_IDX_BITPER_LO   4'h4
`define SCT_IDX_GUARD_HI    4'h5
`define SCT_IDX_GUARD_LO    4'h6
`define SCT_IDX_WAIT_TOP    4'h7
`define SCT_IDX_WAIT_MID    4'h8
`define SCT_IDX_WAIT_LOW    4'h9
`define SCT_IDX_IRQ_MASK    4'ha
`define SCT_IDX_IRQ_PEND    4'hb
`define SCT_IDX_TX_BUF      4'hc
`define SCT_RST_CTRL        8'h00
`define SCT_RST_CONTACT     8'h00
`define SCT_RST_BITPER_HI   8'h01
`define SCT_RST_BITPER_LO   8'h74
`define SCT_RST_GUARD_HI    8'h00
`define SCT_RST_GUARD_LO    8'h0c
`define SCT_RST_WAIT_TOP    8'h00
`define SCT_RST_WAIT_MID    8'h25
`define SCT_RST_WAIT_LOW    8'h80
`define SCT_RST_IRQ         8'h00
`define SCT_RST_TX_BUF      8'h00
`define SCT_CTRL_RUN        2
`define SCT_CTRL_UART       3
`define SCT_CC_RST          1
`define SCT_CC_PWR          0
`define SCT_BITPER_COMP     7
`define SCT_IRQ_TXE         7
`define SCT_IRQ_OVC         5
`define SCT_IRQ_VOLT        4
`define SCT_IRQ_WAIT        3
`define SCT_IRQ_TXC         2
`define SCT_IRQ_RXC         1
`define SCT_IRQ_PAR         0
`define SCT_IRQ_USED        8'hbf
`define SCT_UNIT_ZERO_LEN   12'h800
`define SCT_CNT_ONE_12      12'h001
`define SCT_CNT_ONE_9       9'h001
`define SCT_CNT_ONE_24      24'h000001
`endif

// ===== inc/sct_pkg.sv
// types shared by the smartcard timing block
// assumes the constants header is compiled alongside
`default_nettype none
package sct_pkg;
  typedef enum logic [1:0] {
    SCT_RESP_OKAY   = 2'b00,
    SCT_RESP_SLVERR = 2'b10
  } sct_resp_e;
  // one-cycle pulses from the character transceiver, same clock
  typedef struct packed {
    logic startBit;    // start bit sent or detected
    logic txStartBit;  // start bit sent
    logic txDone;      // character transmitted
    logic rxDone;      // character received
    logic rxRead;      // receive buffer read by cpu
    logic parityErr;   // parity error
    logic txTaken;     // transmit buffer taken by shifter
  } sct_evt_s;
endpackage
`default_nettype wire

// ===== hw/sct_timing_irq.sv
// smartcard timing, waiting timer, interrupt and transmit buffer registers
// assumes an axi4-lite master on mclk, transceiver pulses on mclk, pins asynchronous
// Notes on behaviour
// - reset bit reads pin, write drives pin
// - power bit forced low without card
// - trim shortens odd bit periods by one
// - bit period is 11 bits, high/low split
// - high period write reloads period counter
// - period zero means 2048; software uses 12-2047
// - new guard loads when guard period ends
// - guard spaces transmitted start bits, 9 bits
// - wait registers hold load value only
// - stopped timer reloads on top write
// - running uart timer reloads on start bits
// - timer overflow raises maskable event
// - zero load stays zero, flag reads one
// - mask register, one enable per source
// - pending register clears when read
// - only enabled events set their pending bits
// - voltage pending on falling in-range only
// - transmitted character sets its pending bit
// - received character sets its pending bit
// - transmit buffer holds next byte, readable
`include "sct_consts.svh"
`default_nettype none
module sct_timing_irq (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              cardClk,
  input  wire logic              cardPresentPin,
  input  wire logic              overcurrentPin,
  input  wire logic              voltageOkPin,
  input  wire logic              cardRstPinIn,
  output logic                   cardRstOut,
  output logic                   cardPowerEnable,
  input  wire sct_pkg::sct_evt_s evt,
  output logic [7:0]             txByte,
  output logic                   txValid,
  output logic                   txStartAllow,
  output logic                   unitTick,
  output logic                   uartMode,
  output logic                   irq
);
  // pin synchronisers: stage one feeds stage two only
  logic [4:0] syncA_reg;
  logic [4:0] syncB_reg;
  logic       cardClkPrev_reg;
  logic       overPrev_reg;
  logic       voltPrev_reg;
  wire  [4:0] pinsRaw = {cardClk, cardPresentPin, overcurrentPin, voltageOkPin, cardRstPinIn};
  wire        clkSync  = syncB_reg[4];
  wire        presSync = syncB_reg[3];
  wire        overSync = syncB_reg[2];
  wire        voltSync = syncB_reg[1];
  wire        rstSync  = syncB_reg[0];
  wire        cardTick = clkSync & ~cardClkPrev_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_reg       <= 5'h00;
      syncB_reg       <= 5'h00;
      cardClkPrev_reg <= 1'b0;
      overPrev_reg    <= 1'b0;
      voltPrev_reg    <= 1'b0;
    end else begin
      syncA_reg       <= pinsRaw;
      syncB_reg       <= syncA_reg;
      cardClkPrev_reg <= clkSync;
      overPrev_reg    <= overSync;
      voltPrev_reg    <= voltSync;
    end
  end

  // bus handshake and decode
  logic       bvalid_reg;
  logic [1:0] bresp_reg;
  logic       rvalid_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rdata_reg;
  wire        wrFire  = awvalid & wvalid & ~bvalid_reg;
  wire        rdFire  = arvalid & ~rvalid_reg;
  wire  [3:0] wIdx    = awaddr[5:2];
  wire  [3:0] rIdx    = araddr[5:2];
  wire        wInRange = (awaddr[7:6] == 2'h0) && (wIdx <= `SCT_IDX_TX_BUF);
  wire        rInRange = (araddr[7:6] == 2'h0) && (rIdx <= `SCT_IDX_TX_BUF);
  wire        wLane   = wrFire & wInRange & wstrb[0];
  wire  [7:0] wByte   = wdata[7:0];
  wire        wrCtrl    = wLane && (wIdx == `SCT_IDX_CTRL);
  wire        wrStatus  = wLane && (wIdx == `SCT_IDX_STATUS);
  wire        wrContact = wLane && (wIdx == `SCT_IDX_CONTACT);
  wire        wrPerHi   = wLane && (wIdx == `SCT_IDX_BITPER_HI);
  wire        wrPerLo   = wLane && (wIdx == `SCT_IDX_BITPER_LO);
  wire        wrGuardHi = wLane && (wIdx == `SCT_IDX_GUARD_HI);
  wire        wrGuardLo = wLane && (wIdx == `SCT_IDX_GUARD_LO);
  wire        wrWaitTop = wLane && (wIdx == `SCT_IDX_WAIT_TOP);
  wire        wrWaitMid = wLane && (wIdx == `SCT_IDX_WAIT_MID);
  wire        wrWaitLow = wLane && (wIdx == `SCT_IDX_WAIT_LOW);
  wire        wrMask    = wLane && (wIdx == `SCT_IDX_IRQ_MASK);
  wire        wrTxBuf   = wLane && (wIdx == `SCT_IDX_TX_BUF);
  wire        rdPend    = rdFire && rInRange && (rIdx == `SCT_IDX_IRQ_PEND);

  assign awready = wrFire;
  assign wready  = wrFire;
  assign arready = ~rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = {24'h000000, rdata_reg};

  // software registers
  logic [7:0]  ctrl_reg;
  logic        cardRst_reg;
  logic        power_reg;
  logic [7:0]  perHi_reg;
  logic [7:0]  perLo_reg;
  logic        guardHi_reg;
  logic [7:0]  guardLo_reg;
  logic [7:0]  waitTop_reg;
  logic [7:0]  waitMid_reg;
  logic [7:0]  waitLow_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  pend_reg;
  logic [7:0]  txBuf_reg;
  logic        txFull_reg;
  logic        txcFlag_reg;
  logic        rxcFlag_reg;
  logic        parFlag_reg;
  wire         waitRun = ctrl_reg[`SCT_CTRL_RUN];
  assign       uartMode = ctrl_reg[`SCT_CTRL_UART];

  // power bit may only rise while a card sits in the slot
  wire power_next = presSync & (wrContact ? wByte[`SCT_CC_PWR] : power_reg);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg    <= `SCT_RST_CTRL;
      cardRst_reg <= 1'b0;
      power_reg   <= 1'b0;
      perHi_reg   <= `SCT_RST_BITPER_HI;
      perLo_reg   <= `SCT_RST_BITPER_LO;
      guardHi_reg <= 1'b0;
      guardLo_reg <= `SCT_RST_GUARD_LO;
      waitTop_reg <= `SCT_RST_WAIT_TOP;
      waitMid_reg <= `SCT_RST_WAIT_MID;
      waitLow_reg <= `SCT_RST_WAIT_LOW;
      mask_reg    <= `SCT_RST_IRQ;
      txBuf_reg   <= `SCT_RST_TX_BUF;
    end else begin
      power_reg <= power_next;
      if (wrCtrl)    ctrl_reg    <= wByte;
      if (wrContact) cardRst_reg <= wByte[`SCT_CC_RST];
      if (wrPerHi)   perHi_reg   <= wByte & 8'h87;
      if (wrPerLo)   perLo_reg   <= wByte;
      if (wrGuardHi) guardHi_reg <= wByte[0];
      if (wrGuardLo) guardLo_reg <= wByte;
      if (wrWaitTop) waitTop_reg <= wByte;
      if (wrWaitMid) waitMid_reg <= wByte;
      if (wrWaitLow) waitLow_reg <= wByte;
      if (wrMask)    mask_reg    <= wByte & `SCT_IRQ_USED;
      if (wrTxBuf)   txBuf_reg   <= wByte;
    end
  end
  assign cardRstOut      = cardRst_reg;
  assign cardPowerEnable = power_reg;
  assign txByte          = txBuf_reg;
  assign txValid         = txFull_reg;

  // bit period generator, counted in card clock edges
  logic [11:0] unitCnt_reg;
  logic        oddBit_reg;
  wire  [10:0] unitVal    = {perHi_reg[2:0], perLo_reg};
  wire  [11:0] unitLen    = (unitVal == 11'h000) ? `SCT_UNIT_ZERO_LEN : {1'b0, unitVal};
  wire         trim       = perHi_reg[`SCT_BITPER_COMP] & oddBit_reg;
  wire  [11:0] unitPeriod = trim ? unitLen - `SCT_CNT_ONE_12 : unitLen;
  wire         unitEnd    = cardTick && (unitCnt_reg >= unitPeriod);
  assign unitTick = unitEnd & ~wrPerHi;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      unitCnt_reg <= `SCT_CNT_ONE_12;
      oddBit_reg  <= 1'b0;
    end else if (wrPerHi) begin
      unitCnt_reg <= `SCT_CNT_ONE_12;
      oddBit_reg  <= 1'b0;
    end else if (unitEnd) begin
      unitCnt_reg <= `SCT_CNT_ONE_12;
      oddBit_reg  <= ~oddBit_reg;
    end else if (cardTick) begin
      unitCnt_reg <= unitCnt_reg + `SCT_CNT_ONE_12;
    end
  end

  // guard between transmitted start bits; the receive-to-transmit gap is left to software
  logic [8:0] guardCnt_reg;
  logic [8:0] guardCur_reg;
  logic       guardBusy_reg;
  wire  [8:0] guardSw  = {guardHi_reg, guardLo_reg};
  wire        guardEnd = guardBusy_reg && unitTick && (guardCnt_reg >= guardCur_reg);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      guardCnt_reg  <= `SCT_CNT_ONE_9;
      guardCur_reg  <= 9'({`SCT_RST_GUARD_HI, `SCT_RST_GUARD_LO});
      guardBusy_reg <= 1'b0;
    end else if (evt.txStartBit) begin
      guardCnt_reg  <= `SCT_CNT_ONE_9;
      guardBusy_reg <= 1'b1;
    end else if (!guardBusy_reg || guardEnd) begin
      guardCur_reg  <= guardSw;
      guardBusy_reg <= 1'b0;
    end else if (unitTick) begin
      guardCnt_reg  <= guardCnt_reg + `SCT_CNT_ONE_9;
    end
  end
  assign txStartAllow = ~guardBusy_reg;

  // waiting timer counts down in bit periods; zero is the overflowed state
  logic [23:0] waitCnt_reg;
  wire  [23:0] waitLoad    = {waitTop_reg, waitMid_reg, waitLow_reg};
  wire  [23:0] waitLoadWr  = {wByte, waitMid_reg, waitLow_reg};
  wire         waitStopLd  = !waitRun && wrWaitTop;
  wire         waitAutoLd  = waitRun && uartMode && evt.startBit;
  wire         waitDec     = waitRun && unitTick && (waitCnt_reg != 24'h000000);
  wire         waitOvfEvt  = waitDec && !waitAutoLd && (waitCnt_reg == `SCT_CNT_ONE_24);
  wire         waitFlag    = (waitCnt_reg == 24'h000000);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt_reg <= {`SCT_RST_WAIT_TOP, `SCT_RST_WAIT_MID, `SCT_RST_WAIT_LOW};
    end else if (waitStopLd) begin
      waitCnt_reg <= waitLoadWr;
    end else if (waitAutoLd) begin
      waitCnt_reg <= waitLoad;
    end else if (waitDec) begin
      waitCnt_reg <= waitCnt_reg - `SCT_CNT_ONE_24;
    end
  end

  // events and pending bits; a new set beats the clear-on-read
  wire       overRise = overSync & ~overPrev_reg;
  wire       voltFall = ~voltSync & voltPrev_reg;
  wire [7:0] evtVec   = {evt.txTaken, 1'b0, overRise, voltFall, waitOvfEvt,
                         evt.txDone, evt.rxDone, evt.parityErr};
  wire [7:0] pendSet  = evtVec & mask_reg;
  wire [7:0] pend_next = (rdPend ? 8'h00 : pend_reg) | pendSet;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_reg    <= `SCT_RST_IRQ;
      txFull_reg  <= 1'b0;
      txcFlag_reg <= 1'b0;
      rxcFlag_reg <= 1'b0;
      parFlag_reg <= 1'b0;
    end else begin
      pend_reg    <= pend_next;
      txFull_reg  <= wrTxBuf | (txFull_reg & ~evt.txTaken);
      txcFlag_reg <= evt.txDone | (txcFlag_reg & ~(wrStatus & ~wByte[`SCT_IRQ_TXC]));
      rxcFlag_reg <= evt.rxDone | (rxcFlag_reg & ~evt.rxRead);
      parFlag_reg <= evt.parityErr | (parFlag_reg & ~(wrStatus & ~wByte[`SCT_IRQ_PAR]));
    end
  end
  assign irq = |pend_reg;

  // read mux: wait registers return the load value, never the count
  wire [7:0] statusVal  = {~txFull_reg, presSync, overSync, voltSync, waitFlag,
                           txcFlag_reg, rxcFlag_reg, parFlag_reg};
  wire [7:0] contactVal = {6'h00, rstSync, power_reg};
  wire [7:0] rdMux =
    (rIdx == `SCT_IDX_CTRL)      ? ctrl_reg :
    (rIdx == `SCT_IDX_STATUS)    ? statusVal :
    (rIdx == `SCT_IDX_CONTACT)   ? contactVal :
    (rIdx == `SCT_IDX_BITPER_HI) ? perHi_reg :
    (rIdx == `SCT_IDX_BITPER_LO) ? perLo_reg :
    (rIdx == `SCT_IDX_GUARD_HI)  ? {7'h00, guardHi_reg} :
    (rIdx == `SCT_IDX_GUARD_LO)  ? guardLo_reg :
    (rIdx == `SCT_IDX_WAIT_TOP)  ? waitTop_reg :
    (rIdx == `SCT_IDX_WAIT_MID)  ? waitMid_reg :
    (rIdx == `SCT_IDX_WAIT_LOW)  ? waitLow_reg :
    (rIdx == `SCT_IDX_IRQ_MASK)  ? mask_reg :
    (rIdx == `SCT_IDX_IRQ_PEND)  ? pend_reg :
    txBuf_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= sct_pkg::SCT_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= sct_pkg::SCT_RESP_OKAY;
      rdata_reg  <= 8'h00;
    end else begin
      if (wrFire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wInRange ? sct_pkg::SCT_RESP_OKAY : sct_pkg::SCT_RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rdFire) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rInRange ? sct_pkg::SCT_RESP_OKAY : sct_pkg::SCT_RESP_SLVERR;
        rdata_reg  <= rInRange ? rdMux : 8'h00;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // checks
  sequence seqPendRead;
    rdPend && (pendSet == 8'h00);
  endsequence
  sequence seqContactRead;
    rdFire && rInRange && (rIdx == `SCT_IDX_CONTACT);
  endsequence
  sequence seqAutoLoad;
    waitAutoLd && !waitStopLd;
  endsequence

  AST_RST_READBACK: assert property (@(posedge mclk) disable iff (sys_rst)
    seqContactRead |=> rdata[`SCT_CC_RST] == $past(rstSync))
    else $error("reset bit readback differs from pin");
  AST_POWER_FORCED: assert property (@(posedge mclk) disable iff (sys_rst)
    !presSync |=> !cardPowerEnable)
    else $error("card power kept without card");
  AST_PERIOD_RELOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    wrPerHi |=> (unitCnt_reg == `SCT_CNT_ONE_12) && !oddBit_reg)
    else $error("period counter not reloaded");
  AST_ZERO_PERIOD: assert property (@(posedge mclk) disable iff (sys_rst)
    (unitVal == 11'h000) && !perHi_reg[`SCT_BITPER_COMP] && cardTick &&
      (unitCnt_reg < `SCT_UNIT_ZERO_LEN) |-> !unitEnd)
    else $error("zero period not taken as 2048");
  AST_TRIM_ODD: assert property (@(posedge mclk) disable iff (sys_rst)
    perHi_reg[`SCT_BITPER_COMP] && oddBit_reg && cardTick &&
      (unitCnt_reg == unitLen - `SCT_CNT_ONE_12) |-> unitEnd)
    else $error("odd bit period not shortened");
  AST_GUARD_BLOCK: assert property (@(posedge mclk) disable iff (sys_rst)
    evt.txStartBit |=> !txStartAllow ##0 (guardCnt_reg == `SCT_CNT_ONE_9))
    else $error("start bit did not open a guard period");
  AST_GUARD_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    guardBusy_reg && !guardEnd && !evt.txStartBit |=> $stable(guardCur_reg))
    else $error("guard value changed during guard period");
  AST_WAIT_STOPPED: assert property (@(posedge mclk) disable iff (sys_rst)
    !waitRun && !waitStopLd |=> $stable(waitCnt_reg))
    else $error("stopped waiting timer moved");
  AST_WAIT_AUTOLOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    seqAutoLoad |=> waitCnt_reg == $past(waitLoad))
    else $error("waiting timer not reloaded on start bit");
  AST_WAIT_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    waitFlag && !waitStopLd && !waitAutoLd |=> waitFlag)
    else $error("zero waiting count left zero");
  AST_PEND_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
    seqPendRead |=> (pend_reg == 8'h00) && !irq)
    else $error("pending register not cleared by read");
  AST_VOLT_FALL: assert property (@(posedge mclk) disable iff (sys_rst)
    voltFall && mask_reg[`SCT_IRQ_VOLT] |=> pend_reg[`SCT_IRQ_VOLT])
    else $error("voltage fall not pending");
  AST_TXBUF_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    wrTxBuf |=> (txByte == $past(wByte)) && txValid)
    else $error("transmit buffer write lost");
  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (sys_rst)
    (pend_reg != 8'h00) |-> irq)
    else $error("interrupt low with pending bits");
endmodule
`default_nettype wire

// ===== verif/sct_card_model.sv
// card-side model: contact pins and the card clock
// assumes the bench sets insertion, supply and overload levels
`default_nettype none
module sct_card_model (
  input  wire logic ins,
  input  wire logic sup,
  input  wire logic ovl,
  input  wire logic cardRstOut,
  input  wire logic cardPowerEnable,
  output logic      cardClk,
  output logic      cardPresentPin,
  output logic      overcurrentPin,
  output logic      voltageOkPin,
  output logic      cardRstPinIn
);
  timeunit 1ns;
  timeprecision 100ps;
  // an unpowered card shows neither good voltage nor overload
  assign voltageOkPin   = sup & cardPowerEnable;
  assign overcurrentPin = ovl & cardPowerEnable;
  assign cardPresentPin = ins;
  assign cardRstPinIn   = cardRstOut;
  // reader card clock runs free
  initial begin
    cardClk = 1'b0;
    forever #62.5 cardClk = ~cardClk;
  end
endmodule
`default_nettype wire

// ===== verif/sct_timing_irq_tb.sv
// self-checking bench for the smartcard timing, waiting timer and interrupt block
// assumes the card model on the pins; transceiver event pulses come from the bench
`default_nettype none
module sct_timing_irq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, cardClk, cardPresentPin;
  logic              overcurrentPin, voltageOkPin, cardRstPinIn, cardRstOut;
  logic              cardPowerEnable, txValid, txStartAllow, unitTick, uartMode, irq;
  logic              ins, sup, ovl;
  logic [7:0]        awaddr, araddr, txByte, m;
  logic [31:0]       wdata, rdata, got, seed;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, resp;
  sct_pkg::sct_evt_s evt;
  int                mismatches = 0, comparisons = 0, cycles = 0, n, g1, g2;
  logic [7:0]        rv [13] = '{8'h00, 8'h80, 8'h00, 8'h01, 8'h74, 8'h00, 8'h0c, 8'h00,
                                 8'h25, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0]        hi [4] = '{8'h00, 8'h80, 8'h01, 8'h00};
  logic [7:0]        lo [4] = '{8'h0c, 8'h0c, 8'h00, 8'h00};
  int                k [4] = '{2, 2, 1, 1};

  sct_timing_irq DUT (
    .mclk(mclk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cardClk(cardClk),
    .cardPresentPin(cardPresentPin), .overcurrentPin(overcurrentPin),
    .voltageOkPin(voltageOkPin), .cardRstPinIn(cardRstPinIn), .cardRstOut(cardRstOut),
    .cardPowerEnable(cardPowerEnable), .evt(evt), .txByte(txByte), .txValid(txValid),
    .txStartAllow(txStartAllow), .unitTick(unitTick), .uartMode(uartMode), .irq(irq)
  );
  sct_card_model card (
    .ins(ins), .sup(sup), .ovl(ovl), .cardRstOut(cardRstOut),
    .cardPowerEnable(cardPowerEnable), .cardClk(cardClk), .cardPresentPin(cardPresentPin),
    .overcurrentPin(overcurrentPin), .voltageOkPin(voltageOkPin), .cardRstPinIn(cardRstPinIn)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // clamps to the window so a miss prints the nearest bound
  function automatic int near(input int v, input int e, input int t);
    return (v < e - t) ? e - t : (v > e + t) ? e + t : v;
  endfunction
  // mclk cycles over k bit periods at 12.5 mclk per card clock
  function automatic int bp(input logic [7:0] h, input logic [7:0] l, input int c);
    int p;
    p = ({h[2:0], l} == 11'h000) ? 2048 : int'({h[2:0], l});
    return (c * p - (h[7] ? c / 2 : 0)) * 25 / 2;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    @(posedge mclk);
    awaddr  <= {2'h0, i, 2'h0};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge mclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge mclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i);
    @(posedge mclk);
    araddr  <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= 7'h00;
  endtask
  task automatic span(input int c);
    n = 0;
    do @(posedge mclk); while (unitTick !== 1'b1);
    repeat (c) begin
      do begin
        @(posedge mclk);
        n++;
      end while (unitTick !== 1'b1);
    end
  endtask
  task automatic guard(output int g);
    pulse(7'h60);
    g = 0;
    do begin
      @(posedge mclk);
      g++;
    end while (txStartAllow !== 1'b1);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h00000000, 4'h1};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {ins, sup, ovl, evt} = {3'h2, 7'h00};
    seed = 32'h0000ad12;
    sys_rst = 1'b1;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd(4'(i));
      chk(got, 32'(rv[i]));
      chk(32'(resp), 32'h0);
    end
    rd(4'hd);
    chk({got[29:0], resp}, 32'h2);
    wr(4'hf, 8'hff);
    chk(32'(resp), 32'h2);
    // power request without a card must not reach the pin
    wr(4'h2, 8'h03);
    repeat (6) @(posedge mclk);
    chk(32'({cardRstOut, cardPowerEnable}), 32'h2);
    rd(4'h2);
    chk(got, 32'h2);
    ins <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(4'h2, 8'h01);
    repeat (6) @(posedge mclk);
    chk(32'({cardRstOut, cardPowerEnable}), 32'h1);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      m = (i == 0) ? 8'hff : seed[7:0];
      wr(4'ha, m);
      rd(4'ha);
      chk(got, 32'(m & 8'hbf));
      rd(4'hb);
      pulse(7'h1b);
      ovl <= 1'b1;
      sup <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(32'(irq), 32'(|(m & 8'hb7)));
      rd(4'hb);
      chk(got, 32'(m & 8'hb7));
      rd(4'hb);
      chk({got[30:0], irq}, 32'h0);
      ovl <= 1'b0;
      sup <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(4'hb);
      chk(got, 32'h0);
    end
    // status now: txe, presence, supply, plus txc, rxc, parity left by the pulses above
    rd(4'h1);
    chk(got, 32'hd7);
    wr(4'h1, 8'h00);
    pulse(7'h04);
    rd(4'h1);
    chk(got, 32'hd0);
    seed = xs(seed);
    wr(4'hc, seed[15:8]);
    repeat (2) @(posedge mclk);
    chk(32'({txValid, txByte}), 32'({1'b1, seed[15:8]}));
    rd(4'hc);
    chk(got, 32'(seed[15:8]));
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, lo[i]);
      wr(4'h3, hi[i]);
      span(k[i]);
      chk(n, near(n, bp(hi[i], lo[i], k[i]), 4));
    end
    wr(4'h4, 8'h0c);
    wr(4'h3, 8'h00);
    wr(4'h6, 8'h0b);
    // new guard written while the first guard period runs
    fork
      guard(g1);
      begin
        repeat (3) @(posedge mclk);
        wr(4'h6, 8'h14);
      end
    join
    guard(g2);
    chk(g1, near(g1, 1575, 85));
    chk(g2, near(g2, 2925, 85));
    wr(4'ha, 8'h08);
    wr(4'h9, 8'h03);
    wr(4'h8, 8'h00);
    wr(4'h7, 8'h00);
    repeat (600) @(posedge mclk);
    rd(4'hb);
    chk(got, 32'h0);
    wr(4'h0, 8'h04);
    repeat (700) @(posedge mclk);
    rd(4'hb);
    chk(got, 32'h8);
    rd(4'h9);
    chk(got, 32'h3);
    wr(4'h0, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h0, 8'h0c);
    rd(4'hb);
    chk(32'(uartMode), 32'h1);
    repeat (6) begin
      repeat (250) @(posedge mclk);
      pulse(7'h40);
    end
    rd(4'hb);
    chk(got, 32'h0);
    repeat (700) @(posedge mclk);
    rd(4'hb);
    chk(got, 32'h8);
    wr(4'h0, 8'h00);
    wr(4'h9, 8'h05);
    wr(4'h7, 8'h00);
    rd(4'h1);
    chk(32'(got[3]), 32'h0);
    wr(4'h9, 8'h00);
    wr(4'h7, 8'h00);
    rd(4'h1);
    chk(32'(got[3]), 32'h1);
    rd(4'hb);
    wr(4'h0, 8'h04);
    repeat (400) @(posedge mclk);
    rd(4'hb);
    chk(got, 32'h0);
    ins <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(32'(cardPowerEnable), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
